// ==== hdl/bt1ch_pkg.sv ====
// constants for the bridge type 1 configuration header slice, bytes 0x009 to 0x01d, plus the lock word at index 0x040
// assumes a 32-bit apb slave: each header byte index sits in its own word at index*4
// How it works
// (R1) class identifier low byte reads zero, read-only: no subtractive decode
// (R2) class identifier middle byte reads 0x04 read-only: bridge subclass
// (R3) class identifier top byte reads 0x06 read-only: bridge base class
// (R4) cache line size is 8-bit read/write, resets zero, affects nothing
// (R5) primary latency timer reads zero, read-only
// (R6) header layout type reads 0x01, read-only
// (R7) self-test control reads zero, read-only
// (R8) both base address words read zero, read-only
// (R9) primary bus number read/write, resets zero, no internal effect
// (R10) secondary bus number read/write, resets zero
// (R11) subordinate bus number read/write, resets zero
// (R12) secondary latency timer reads zero, read-only
// (R13) io window low bit 0 is lockable capability, resets one, one is wide
// (R14) io window high bit 0 mirrors the capability bit, read-only
// (R15) io window low bits 7:4 read/write, reset 0xf, address bits 15:12
// (R16) io window high bits 7:4 read/write, reset zero, low twelve bits ones
// (R17) io base and limit decide which io accesses are forwarded
// (R18) bits 3:1 of both io window bytes read zero, read-only
// (R19) writes to read-only fields are ignored
package bt1ch_pkg;
  localparam int unsigned ADDR_W = 12;

  // header byte indices; byte address on the bus is index times four
  localparam logic [9:0] IDX_CLASS = 10'h009;
  localparam logic [9:0] IDX_CACHE_LINE = 10'h00c;
  localparam logic [9:0] IDX_PRIM_LAT = 10'h00d;
  localparam logic [9:0] IDX_LAYOUT = 10'h00e;
  localparam logic [9:0] IDX_SELFTEST = 10'h00f;
  localparam logic [9:0] IDX_BASE0 = 10'h010;
  localparam logic [9:0] IDX_BASE1 = 10'h014;
  localparam logic [9:0] IDX_PBUS = 10'h018;
  localparam logic [9:0] IDX_SBUS = 10'h019;
  localparam logic [9:0] IDX_SUBUS = 10'h01a;
  localparam logic [9:0] IDX_SEC_LAT = 10'h01b;
  localparam logic [9:0] IDX_IOLOW = 10'h01c;
  localparam logic [9:0] IDX_IOHIGH = 10'h01d;
  localparam logic [9:0] IDX_LOCK = 10'h040;

  // fixed read values
  localparam logic [7:0] CLASS_PROG_IF = 8'h00;
  localparam logic [7:0] CLASS_SUB = 8'h04;
  localparam logic [7:0] CLASS_BASE = 8'h06;
  localparam logic [7:0] PRIM_LAT_VAL = 8'h00;
  localparam logic [7:0] LAYOUT_VAL = 8'h01;
  localparam logic [7:0] SELFTEST_VAL = 8'h00;
  localparam logic [31:0] BASE_ADDR_VAL = 32'h0000_0000;
  localparam logic [7:0] SEC_LAT_VAL = 8'h00;

  // field positions
  localparam int unsigned CAP_BIT = 0;
  localparam int unsigned IOWIN_LSB = 4;
  localparam int unsigned LOCK_BIT = 0;

  // reset values
  localparam logic [7:0] CACHE_LINE_RST = 8'h00;
  localparam logic [7:0] BUS_RST = 8'h00;
  localparam logic CAP_RST = 1'b1;
  localparam logic [3:0] WIN_LOW_RST = 4'hf;
  localparam logic [3:0] WIN_HIGH_RST = 4'h0;
  localparam logic LOCK_RST = 1'b0;
endpackage

// ==== hdl/bt1ch_regs.sv ====
// configuration header slice with apb access and io window forwarding decision
// assumes apb3/4 master on pclk; io_req/io_addr come from same-clock logic
`timescale 1ns/1ps
module bt1ch_regs
(
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [bt1ch_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic io_req, // io access to classify
  input wire logic [31:0] io_addr, // io access address
  output logic io_fwd_valid, // classification ready pulse
  output logic io_fwd, // access lies in window
  output logic [7:0] secondary_bus_number, // secondary bus
  output logic [7:0] subordinate_bus_number, // highest bus behind bridge
  output logic io_addressing_capability // 1 wide, 0 narrow io addressing
);

  typedef struct packed
  {
    logic [7:0] cache_line;
    logic [7:0] pbus;
    logic [7:0] sbus;
    logic [7:0] subus;
    logic cap;
    logic [3:0] win_low;
    logic [3:0] win_high;
    logic lock;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic fwd;
    logic fwd_valid;
  } bt1ch_state_s;

  bt1ch_state_s st_r;
  bt1ch_state_s st_nxt;

  // word-aligned decode; non-zero low address bits are treated as unmapped
  function automatic logic bt1ch_hit(input logic [bt1ch_pkg::ADDR_W-1:0] a,
                                     input logic [9:0] idx);
    bt1ch_hit = (a[1:0] == 2'h0) && (a[bt1ch_pkg::ADDR_W-1:2] == idx);
  endfunction

  function automatic logic bt1ch_mapped(input logic [bt1ch_pkg::ADDR_W-1:0] a);
    bt1ch_mapped = bt1ch_hit(a, bt1ch_pkg::IDX_CLASS) || bt1ch_hit(a, bt1ch_pkg::IDX_CACHE_LINE)
      || bt1ch_hit(a, bt1ch_pkg::IDX_PRIM_LAT) || bt1ch_hit(a, bt1ch_pkg::IDX_LAYOUT)
      || bt1ch_hit(a, bt1ch_pkg::IDX_SELFTEST) || bt1ch_hit(a, bt1ch_pkg::IDX_BASE0)
      || bt1ch_hit(a, bt1ch_pkg::IDX_BASE1) || bt1ch_hit(a, bt1ch_pkg::IDX_PBUS)
      || bt1ch_hit(a, bt1ch_pkg::IDX_SBUS) || bt1ch_hit(a, bt1ch_pkg::IDX_SUBUS)
      || bt1ch_hit(a, bt1ch_pkg::IDX_SEC_LAT) || bt1ch_hit(a, bt1ch_pkg::IDX_IOLOW)
      || bt1ch_hit(a, bt1ch_pkg::IDX_IOHIGH) || bt1ch_hit(a, bt1ch_pkg::IDX_LOCK);
  endfunction

  logic setup;
  logic wr_en;
  logic [7:0] wbyte;

  assign setup = psel && !penable;
  // writes land only at the completing access edge
  assign wr_en = psel && penable && pwrite && st_r.ready && pstrb[0];
  assign wbyte = pwdata[7:0];

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ready = setup;
    st_nxt.slverr = setup && !bt1ch_mapped(paddr);
    st_nxt.rdata = 32'h0000_0000;
    if (setup && !pwrite)
    begin
      if (bt1ch_hit(paddr, bt1ch_pkg::IDX_CLASS))
        st_nxt.rdata = {8'h00, bt1ch_pkg::CLASS_BASE, bt1ch_pkg::CLASS_SUB,
                        bt1ch_pkg::CLASS_PROG_IF}; // R1 R2 R3
      else if (bt1ch_hit(paddr, bt1ch_pkg::IDX_CACHE_LINE))
        st_nxt.rdata = {24'h000000, st_r.cache_line}; // R4
      else if (bt1ch_hit(paddr, bt1ch_pkg::IDX_PRIM_LAT))
        st_nxt.rdata = {24'h000000, bt1ch_pkg::PRIM_LAT_VAL}; // R5
      else if (bt1ch_hit(paddr, bt1ch_pkg::IDX_LAYOUT))
        st_nxt.rdata = {24'h000000, bt1ch_pkg::LAYOUT_VAL}; // R6
      else if (bt1ch_hit(paddr, bt1ch_pkg::IDX_SELFTEST))
        st_nxt.rdata = {24'h000000, bt1ch_pkg::SELFTEST_VAL}; // R7
      else if (bt1ch_hit(paddr, bt1ch_pkg::IDX_BASE0) || bt1ch_hit(paddr, bt1ch_pkg::IDX_BASE1))
        st_nxt.rdata = bt1ch_pkg::BASE_ADDR_VAL; // R8
      else if (bt1ch_hit(paddr, bt1ch_pkg::IDX_PBUS))
        st_nxt.rdata = {24'h000000, st_r.pbus}; // R9
      else if (bt1ch_hit(paddr, bt1ch_pkg::IDX_SBUS))
        st_nxt.rdata = {24'h000000, st_r.sbus}; // R10
      else if (bt1ch_hit(paddr, bt1ch_pkg::IDX_SUBUS))
        st_nxt.rdata = {24'h000000, st_r.subus}; // R11
      else if (bt1ch_hit(paddr, bt1ch_pkg::IDX_SEC_LAT))
        st_nxt.rdata = {24'h000000, bt1ch_pkg::SEC_LAT_VAL}; // R12
      else if (bt1ch_hit(paddr, bt1ch_pkg::IDX_IOLOW))
        st_nxt.rdata = {24'h000000, st_r.win_low, 3'h0, st_r.cap}; // R13 R15 R18
      else if (bt1ch_hit(paddr, bt1ch_pkg::IDX_IOHIGH))
        st_nxt.rdata = {24'h000000, st_r.win_high, 3'h0, st_r.cap}; // R14 R16 R18
      else if (bt1ch_hit(paddr, bt1ch_pkg::IDX_LOCK))
        st_nxt.rdata = {31'h00000000, st_r.lock};
    end
    // read-only words have no write path at all
    if (wr_en) // R19
    begin
      if (bt1ch_hit(paddr, bt1ch_pkg::IDX_CACHE_LINE))
        st_nxt.cache_line = wbyte; // R4
      if (bt1ch_hit(paddr, bt1ch_pkg::IDX_PBUS))
        st_nxt.pbus = wbyte; // R9
      if (bt1ch_hit(paddr, bt1ch_pkg::IDX_SBUS))
        st_nxt.sbus = wbyte; // R10
      if (bt1ch_hit(paddr, bt1ch_pkg::IDX_SUBUS))
        st_nxt.subus = wbyte; // R11
      if (bt1ch_hit(paddr, bt1ch_pkg::IDX_IOLOW))
      begin
        st_nxt.win_low = wbyte[bt1ch_pkg::IOWIN_LSB +: 4]; // R15
        if (!st_r.lock)
          st_nxt.cap = wbyte[bt1ch_pkg::CAP_BIT]; // R13
      end
      if (bt1ch_hit(paddr, bt1ch_pkg::IDX_IOHIGH))
        st_nxt.win_high = wbyte[bt1ch_pkg::IOWIN_LSB +: 4]; // R16
      if (bt1ch_hit(paddr, bt1ch_pkg::IDX_LOCK))
        st_nxt.lock = wbyte[bt1ch_pkg::LOCK_BIT];
    end
    // no upper io base/limit in this slice, so the window never leaves the low 64k
    st_nxt.fwd_valid = io_req;
    st_nxt.fwd = io_req && (io_addr[31:16] == 16'h0000)
      && (io_addr[15:12] >= st_r.win_low) && (io_addr[15:12] <= st_r.win_high); // R17 R16 R15
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r.cache_line <= bt1ch_pkg::CACHE_LINE_RST; // R4
      st_r.pbus <= bt1ch_pkg::BUS_RST; // R9
      st_r.sbus <= bt1ch_pkg::BUS_RST; // R10
      st_r.subus <= bt1ch_pkg::BUS_RST; // R11
      st_r.cap <= bt1ch_pkg::CAP_RST; // R13
      st_r.win_low <= bt1ch_pkg::WIN_LOW_RST; // R15
      st_r.win_high <= bt1ch_pkg::WIN_HIGH_RST; // R16
      st_r.lock <= bt1ch_pkg::LOCK_RST;
      st_r.rdata <= 32'h0000_0000;
      st_r.ready <= 1'b0;
      st_r.slverr <= 1'b0;
      st_r.fwd <= 1'b0;
      st_r.fwd_valid <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.slverr;
  assign io_fwd = st_r.fwd;
  assign io_fwd_valid = st_r.fwd_valid;
  assign secondary_bus_number = st_r.sbus;
  assign subordinate_bus_number = st_r.subus;
  assign io_addressing_capability = st_r.cap;

endmodule // bt1ch_regs

// ==== tb/bt1ch_regs_assertions.sv ====
// checker for the header slice, bound onto bt1ch_regs
// sees the top module's ports only
`timescale 1ns/1ps
module bt1ch_regs_chk
(
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic pready, // apb ready
  input wire logic io_req, // io classify request
  input wire logic io_fwd_valid, // io answer pulse
  input wire logic io_fwd, // io access in window
  input wire logic io_addressing_capability, // capability bit
  input wire logic [bt1ch_pkg::ADDR_W-1:0] paddr, // byte address
  input wire logic [31:0] prdata, // read data
  input wire logic [7:0] secondary_bus_number, // secondary bus
  input wire logic [7:0] subordinate_bus_number // subordinate bus
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // misaligned reads are unmapped and read zero, so only aligned ones are judged
  wire rd = psel && penable && pready && !pwrite && paddr[1:0] == 2'h0;
  wire [9:0] ix = paddr[11:2];
  wire z = ix inside {10'h00d, 10'h00f, 10'h010, 10'h014, 10'h01b};
  AST_CLASS: assert property (rd && ix == 10'h009 |-> prdata == 32'h00060400)
    else $error("class word");
  AST_ZERO: assert property (rd && z |-> prdata == 32'h0) else $error("zero word");
  AST_CAP: assert property (rd && ix inside {10'h01c, 10'h01d}
    |-> prdata[3:0] == {3'h0, io_addressing_capability}) else $error("capability bit");
  AST_SBUS: assert property (rd && ix == 10'h019 |-> prdata[7:0] == secondary_bus_number)
    else $error("secondary bus");
  AST_SUB: assert property (rd && ix == 10'h01a |-> prdata[7:0] == subordinate_bus_number)
    else $error("subordinate bus");
  AST_HOLD: assert property (!(psel && penable && pwrite && ix == 10'h01c)
    |=> $stable(io_addressing_capability)) else $error("capability changed");
  AST_FWDV: assert property (io_req |=> io_fwd_valid) else $error("no io answer");
  AST_IDLE: assert property (!io_req |=> !io_fwd_valid && !io_fwd) else $error("stray");
endmodule // bt1ch_regs_chk
bind bt1ch_regs bt1ch_regs_chk i_chk
(
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pready(pready),
  .io_req(io_req),
  .io_fwd_valid(io_fwd_valid),
  .io_fwd(io_fwd),
  .io_addressing_capability(io_addressing_capability),
  .paddr(paddr),
  .prdata(prdata),
  .secondary_bus_number(secondary_bus_number),
  .subordinate_bus_number(subordinate_bus_number)
);

// ==== tb/tb_bridge_type1_config_header.sv ====
// bench: slot table model against random apb and io classify traffic
// drives every input of bt1ch_regs itself
`timescale 1ns/1ps
module tb_bridge_type1_config_header;
  logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, io_req, io_fwd_valid;
  logic io_fwd, io_addressing_capability;
  logic [11:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, io_addr, d, wk;
  logic [7:0] secondary_bus_number, subordinate_bus_number;
  int n_fail = 0, compares = 0, seed = 89;
  logic [9:0] ix [15] = '{10'h009, 10'h00c, 10'h00d, 10'h00e, 10'h00f, 10'h010, 10'h014, 10'h018,
    10'h019, 10'h01a, 10'h01b, 10'h01c, 10'h01d, 10'h040, 10'h3ff};
  logic [31:0] wm [15] = '{0, 8'hff, 0, 0, 0, 0, 0, 8'hff, 8'hff, 8'hff, 0, 8'hf1, 8'hf0, 8'h01, 0};
  logic [31:0] m [15] = '{24'h060400, 0, 0, 8'h01, 0, 0, 0, 0, 0, 0, 0, 8'hf1, 8'h01, 0, 0};
  logic [31:0] m0 [15];
  bt1ch_regs i_dut
  (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .io_req(io_req),
    .io_addr(io_addr),
    .io_fwd_valid(io_fwd_valid),
    .io_fwd(io_fwd),
    .secondary_bus_number(secondary_bus_number),
    .subordinate_bus_number(subordinate_bus_number),
    .io_addressing_capability(io_addressing_capability)
  );
  initial forever #5 pclk = ~pclk;
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    test_done;
  end
  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    n_fail += int'(seen !== exp);
    if (seen !== exp)
      $display("BAD %s exp %h seen %h", nm, exp, seen);
  endtask
  task automatic apb(input logic w, input int k, input logic s);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, ix[k], 2'h0, d, 3'h0, s};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk("pslverr", pslverr, k == 14);
    if (!w)
      chk("prdata", prdata, m[k]);
    {psel, penable} <= 2'h0;
    wk = wm[k] & ~{31'h0, k == 11 && m[13][0]} & {32{w && s}};
    m[k] = (m[k] & ~wk) | (d & wk);
    m[12][0] = m[11][0];
  endtask
  task automatic classify(input logic [31:0] a);
    @(posedge pclk);
    {io_req, io_addr} <= {1'b1, a};
    @(posedge pclk);
    io_req <= 1'b0;
    wk[0] = a[31:16] == 0 && m[11][7:4] <= a[15:12] && a[15:12] <= m[12][7:4];
    #1 chk("io", {io_fwd_valid, io_fwd}, {1'b1, wk[0]});
  endtask
  initial
  begin
    {psel, penable, pwrite, io_req, presetn, paddr, pwdata, pstrb, io_addr, d} = '0;
    m0 = m;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ix[j]) apb(1'b0, j, 1'b1);
    $display("reset values done");
    repeat (150)
    begin
      d = $random(seed);
      apb(d[9], {$random(seed)} % 15, d[8]);
      #1 chk("sbus", secondary_bus_number, m[8]);
      chk("subus", subordinate_bus_number, m[9]);
      chk("cap", io_addressing_capability, m[11][0]);
    end
    $display("register traffic done");
    // reset in mid-run must bring the written registers back to their reset values
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    m = m0;
    foreach (ix[j]) apb(1'b0, j, 1'b1);
    $display("mid-run reset done");
    d = 32'h00000020;
    apb(1'b1, 11, 1'b1);
    d = 32'h00000050;
    apb(1'b1, 12, 1'b1);
    repeat (60) classify($random(seed) & 32'h0001ffff);
    $display("io window done");
    test_done;
  end
endmodule // tb_bridge_type1_config_header
